// *** shared/pwr_ctrl_pkg.sv ***
package pwr_ctrl_pkg;

	// Register word offsets on the plain register port (byte addresses).
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WAKECFG = 8'h08;

	// Control register bit positions (write-only actions and mode request).
	localparam int CTRL_CPU_RST = 0;
	localparam int CTRL_DEV_RST = 1;
	localparam int CTRL_SUSPEND = 2;
	localparam int CTRL_STANDBY = 3;
	localparam int CTRL_FW_LOADED = 4;

	// Wake configuration bit positions.
	localparam int WCFG_CTS_POL = 0;

	localparam logic WAKECFG_RESET = 1'b0;

	// Soft reset pulses driven to the core stand one cycle more than this.
	localparam int RST_PULSE_CYC = 4;

	// Boot source encodings.
	typedef enum logic [2:0] {
		BOOT_USB = 3'h0,
		BOOT_I2C_USB = 3'h1,
		BOOT_I2C_ONLY = 3'h2,
		BOOT_SPI_USB = 3'h3,
		BOOT_INVALID = 3'h7
	} boot_src_e;

	// Power mode states.
	typedef enum logic [2:0] {
		PM_NORMAL = 3'h0,
		PM_SUSPEND = 3'h1,
		PM_STANDBY = 3'h2,
		PM_WAKE_STBY = 3'h3,
		PM_DEVRST = 3'h4
	} pwr_mode_e;

	// Wake sources as one bundle.
	typedef struct packed {
		logic dpLine;
		logic dmLine;
		logic ssResume;
		logic vbusDet;
		logic ctsLevel;
	} wake_src_s;

	// Clock and power enables driven to the rest of the chip.
	typedef struct packed {
		logic cpuClkEn;
		logic pllEn;
		logic usbPhyEn;
		logic usbXcvrEn;
		logic cpuPwrEn;
		logic ioHold;
	} pwr_ctl_s;

	localparam pwr_ctl_s PWR_NORMAL = 6'b111110;
	localparam pwr_ctl_s PWR_SUSPEND = 6'b001001;
	localparam pwr_ctl_s PWR_STANDBY = 6'b000000;

endpackage

// *** verilog/pin_sync.sv ***
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_q;

	// The first stage is read only by the second, to contain metastability.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stage1_q <= '0;
			syncOut <= '0;
		end else begin
			stage1_q <= pinIn;
			syncOut <= stage1_q;
		end
	end
endmodule

// *** verilog/power_mode_boot_reset_ctrl.sv ***
`timescale 1ns/10ps
//Contract
// - Boot pins F11 USB, F1F I2C then USB, 1FF I2C only, 0F1 SPI then USB.
// - During hard reset every I/O pin is high impedance.
// - Separate camera receiver reset input resets only that core.
// - Processor soft reset resets only the program counter; firmware kept.
// - Whole-device soft reset behaves exactly as a hard reset; here the boot pins are not sampled again.
// - Normal mode keeps processor clock and PLLs enabled.
// - Suspend keeps USB 3.0 PHY on in U3, all other clocks off.
// - Suspend holds I/O states and retains registers and memories.
// - Wake from suspend, except by reset, resumes without PC reset.
// - Suspend wakes on D+/D- edge, SS resume, VBUS, CTS level, reset.
// - Standby keeps configuration and RAM; buffered data not guaranteed.
// - Standby turns off PLL, USB transceiver and processor power.
// - Wake from standby resets the PC and restarts the processor.
// - Standby entered by register write; exits on VBUS, CTS, reset.
// - After core power-down, firmware and configuration count as lost.
module power_mode_boot_reset_ctrl
	import pwr_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic [2:0] bootPinHigh,
	input wire logic [2:0] bootPinFloat,
	input wire logic camRxRstPin,
	input wire logic dpPin,
	input wire logic dmPin,
	input wire logic ssResumePin,
	input wire logic vbusPin,
	input wire logic ctsPin,
	output logic ioOutEnAllow,
	output logic camRxRst,
	output logic cpuPcRst,
	output logic coreRst,
	output logic fwValid,
	output logic [2:0] bootSrc,
	output logic [2:0] pwrMode,
	output logic cpuClkEn,
	output logic pllEn,
	output logic usbPhyEn,
	output logic usbXcvrEn,
	output logic cpuPwrEn,
	output logic ioHold
);
	logic [2:0] bootHighSync;
	logic [2:0] bootFloatSync;
	logic camRstSync;
	wake_src_s wakeSync;
	wake_src_s wakeLast_q;
	pwr_mode_e mode_q;
	pwr_mode_e mode_d;
	pwr_ctl_s pwrCtl;
	logic ctsPol_q;
	logic bootTaken_q;
	logic [2:0] pulseCnt_q;
	logic suspWake;
	logic stbyWake;
	logic ctsActive;
	logic devRstReq;
	logic cpuRstReq;
	logic wrCtrl;

	// Every pin from outside the clock domain passes two flip-flops.
	pin_sync #(.WIDTH(12)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pinIn({bootPinHigh, bootPinFloat, camRxRstPin, dpPin, dmPin,
			ssResumePin, vbusPin, ctsPin}),
		.syncOut({bootHighSync, bootFloatSync, camRstSync, wakeSync})
	);

	assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
	assign devRstReq = wrCtrl && regWdata[CTRL_DEV_RST];
	assign cpuRstReq = wrCtrl && regWdata[CTRL_CPU_RST];
	assign ctsActive = (wakeSync.ctsLevel == ctsPol_q);

	// Pin edges catch D+/D- transitions in either direction.
	assign suspWake = (wakeSync.dpLine != wakeLast_q.dpLine) ||
		(wakeSync.dmLine != wakeLast_q.dmLine) ||
		wakeSync.ssResume || wakeSync.vbusDet || ctsActive;
	assign stbyWake = wakeSync.vbusDet || ctsActive;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wakeLast_q <= '0;
		end else begin
			wakeLast_q <= wakeSync;
		end
	end

	// Boot pins are decoded from the high and floating senses of each pin.
	// Sampling waits for the synchronisers so the value is settled.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bootTaken_q <= 1'b0;
			bootSrc <= BOOT_INVALID;
		end else if (!bootTaken_q && pulseCnt_q == 3'h0) begin
			bootTaken_q <= 1'b1;
			if (bootFloatSync == 3'b100 && bootHighSync[1:0] == 2'b11) begin
				bootSrc <= BOOT_USB;
			end else if (bootFloatSync == 3'b101 &&
				bootHighSync[1]) begin
				bootSrc <= BOOT_I2C_USB;
			end else if (bootFloatSync == 3'b011 &&
				bootHighSync[2]) begin
				bootSrc <= BOOT_I2C_ONLY;
			end else if (bootFloatSync == 3'b010 &&
				bootHighSync == 3'b001) begin
				bootSrc <= BOOT_SPI_USB;
			end else begin
				bootSrc <= BOOT_INVALID;
			end
		end
	end

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			PM_NORMAL: begin
				if (devRstReq) begin
					mode_d = PM_DEVRST;
				end else if (wrCtrl && regWdata[CTRL_STANDBY]) begin
					mode_d = PM_STANDBY;
				end else if (wrCtrl && regWdata[CTRL_SUSPEND]) begin
					mode_d = PM_SUSPEND;
				end
			end
			PM_SUSPEND: begin
				if (suspWake) begin
					mode_d = PM_NORMAL;
				end
			end
			PM_STANDBY: begin
				if (stbyWake) begin
					mode_d = PM_WAKE_STBY;
				end
			end
			PM_WAKE_STBY: begin
				if (pulseCnt_q == 3'h0) begin
					mode_d = PM_NORMAL;
				end
			end
			PM_DEVRST: begin
				if (pulseCnt_q == 3'h0) begin
					mode_d = PM_NORMAL;
				end
			end
			default: begin
				mode_d = PM_NORMAL;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= PM_NORMAL;
		end else begin
			mode_q <= mode_d;
		end
	end

	// One counter times every reset pulse; it starts full after hard reset.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pulseCnt_q <= 3'(RST_PULSE_CYC);
		end else if (mode_q != PM_DEVRST && mode_d == PM_DEVRST) begin
			pulseCnt_q <= 3'(RST_PULSE_CYC);
		end else if (mode_q == PM_STANDBY && mode_d == PM_WAKE_STBY) begin
			pulseCnt_q <= 3'(RST_PULSE_CYC);
		end else if (cpuRstReq && mode_q == PM_NORMAL) begin
			pulseCnt_q <= 3'(RST_PULSE_CYC);
		end else if (pulseCnt_q != 3'h0) begin
			pulseCnt_q <= pulseCnt_q - 3'h1;
		end
	end

	// Core reset covers hard reset and the whole-device soft reset alike.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			coreRst <= 1'b1;
			cpuPcRst <= 1'b1;
		end else begin
			coreRst <= (mode_d == PM_DEVRST) ||
				(!bootTaken_q && pulseCnt_q != 3'h0);
			cpuPcRst <= (mode_d == PM_DEVRST) ||
				(mode_d == PM_WAKE_STBY) ||
				(cpuRstReq && mode_q == PM_NORMAL) ||
				(pulseCnt_q != 3'h0 && mode_q == PM_NORMAL);
		end
	end

	// Firmware loaded flag: software sets it; any full reset clears it.
	// A set written in the same cycle as a device reset loses on purpose,
	// since the reload is then mandatory.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fwValid <= 1'b0;
		end else if (mode_d == PM_DEVRST) begin
			fwValid <= 1'b0;
		end else if (wrCtrl && regWdata[CTRL_FW_LOADED]) begin
			fwValid <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctsPol_q <= WAKECFG_RESET;
		end else if (mode_d == PM_DEVRST) begin
			ctsPol_q <= WAKECFG_RESET;
		end else if (regWr && regAddr == ADDR_WAKECFG) begin
			ctsPol_q <= regWdata[WCFG_CTS_POL];
		end
	end

	// Camera receiver reset touches nothing but that core.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			camRxRst <= 1'b1;
		end else begin
			camRxRst <= camRstSync;
		end
	end

	always_comb begin
		case (mode_d)
			PM_SUSPEND: pwrCtl = PWR_SUSPEND;
			PM_STANDBY: pwrCtl = PWR_STANDBY;
			PM_WAKE_STBY: pwrCtl = PWR_NORMAL;
			default: pwrCtl = PWR_NORMAL;
		endcase
	end

	// Standby keeps GPIO configuration, so pins are not released there.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cpuClkEn <= 1'b0;
			pllEn <= 1'b0;
			usbPhyEn <= 1'b0;
			usbXcvrEn <= 1'b0;
			cpuPwrEn <= 1'b0;
			ioHold <= 1'b0;
			ioOutEnAllow <= 1'b0;
			pwrMode <= 3'(PM_NORMAL);
		end else begin
			cpuClkEn <= pwrCtl.cpuClkEn;
			pllEn <= pwrCtl.pllEn;
			usbPhyEn <= pwrCtl.usbPhyEn;
			usbXcvrEn <= pwrCtl.usbXcvrEn;
			cpuPwrEn <= pwrCtl.cpuPwrEn;
			ioHold <= pwrCtl.ioHold;
			ioOutEnAllow <= (mode_d != PM_DEVRST);
			pwrMode <= 3'(mode_d);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			regRdata <= 32'h0;
		end else if (regRd) begin
			if (regAddr == ADDR_STATUS) begin
				regRdata <= {23'h0, fwValid, bootTaken_q,
					bootSrc, 1'b0, 3'(mode_q)};
			end else if (regAddr == ADDR_WAKECFG) begin
				regRdata <= {31'h0, ctsPol_q};
			end else begin
				regRdata <= 32'h0;
			end
		end else begin
			regRdata <= 32'h0;
		end
	end
endmodule

// *** verif/pmc_chk_sva.sv ***
`timescale 1ns/10ps
module pmc_chk
	import pwr_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic vbusPin,
	input wire logic cpuPcRst,
	input wire logic coreRst,
	input wire logic fwValid,
	input wire logic ioOutEnAllow,
	input wire logic [2:0] pwrMode,
	input wire logic cpuClkEn,
	input wire logic pllEn,
	input wire logic usbPhyEn,
	input wire logic usbXcvrEn,
	input wire logic cpuPwrEn,
	input wire logic ioHold
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [5:0] en;
	logic ctl;
	assign en = {cpuClkEn, pllEn, usbPhyEn, usbXcvrEn, cpuPwrEn, ioHold};
	// Mode writes only count in normal mode; others are refused.
	assign ctl = regWr && regAddr == ADDR_CTRL && pwrMode == PM_NORMAL;
	sequence sStbyOut;
		pwrMode == PM_STANDBY ##1 pwrMode == PM_WAKE_STBY;
	endsequence
	AST_NORM_EN: assert property (
		pwrMode == PM_NORMAL [*2] |-> en == PWR_NORMAL
	) else $error("normal enables");
	AST_SUSP_EN: assert property (
		pwrMode == PM_SUSPEND |-> en == PWR_SUSPEND
	) else $error("suspend enables");
	AST_STBY_EN: assert property (
		pwrMode == PM_STANDBY |-> en == PWR_STANDBY
	) else $error("standby enables");
	AST_SUSP_IN: assert property (
		ctl && regWdata[3:0] == 4'h4 |=> pwrMode == PM_SUSPEND
	) else $error("suspend entry");
	AST_SUSP_WAKE: assert property (
		pwrMode == PM_SUSPEND && $rose(vbusPin)
			|-> !cpuPcRst throughout ##[2:4] pwrMode == PM_NORMAL
	) else $error("suspend wake");
	AST_STBY_WAKE: assert property (
		sStbyOut |-> (cpuPcRst && pwrMode == PM_WAKE_STBY) [*5]
			##1 pwrMode == PM_NORMAL
	) else $error("standby wake");
	AST_DEV_RST: assert property (
		ctl && regWdata[CTRL_DEV_RST]
			|=> (coreRst && !fwValid && !ioOutEnAllow) [*5]
	) else $error("device reset");
	AST_CPU_RST: assert property (
		ctl && regWdata[4:0] == 5'h01
			|=> cpuPcRst && !coreRst && $stable(fwValid)
	) else $error("processor reset");
endmodule
bind power_mode_boot_reset_ctrl pmc_chk u_pmc_chk (.mclk(mclk),
	.nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.vbusPin(vbusPin), .cpuPcRst(cpuPcRst), .coreRst(coreRst),
	.fwValid(fwValid), .ioOutEnAllow(ioOutEnAllow), .pwrMode(pwrMode),
	.cpuClkEn(cpuClkEn), .pllEn(pllEn), .usbPhyEn(usbPhyEn),
	.usbXcvrEn(usbXcvrEn), .cpuPwrEn(cpuPwrEn), .ioHold(ioHold));

// *** verif/wake_pin_model.sv ***
`timescale 1ns/10ps
module wake_pin_model
	import pwr_ctrl_pkg::*;
(
	input wire logic mclk,
	input wire logic rstReq,
	input wire logic coreOff,
	input wire wake_src_s req,
	output logic nrst,
	output wake_src_s pins
);
	// Board pins move just after an edge, so no sample races them.
	initial begin
		pins = 5'h00;
		forever @(posedge mclk) pins <= req;
	end
	// Losing the core supply looks like a held reset.
	assign nrst = !(rstReq || coreOff);
endmodule

// *** verif/power_mode_boot_reset_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module power_mode_boot_reset_ctrl_tb_top
	import pwr_ctrl_pkg::*;
;
	logic mclk = 1'b0, rstReq = 1'b1, coreOff = 1'b0, camRxRstPin = 1'b0;
	logic regWr = 1'b0, regRd = 1'b0, nrst, ioOutEnAllow, camRxRst;
	logic cpuPcRst, coreRst, fwValid, cpuClkEn, pllEn, usbPhyEn;
	logic usbXcvrEn, cpuPwrEn, ioHold;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic [2:0] pinHi = 3'h0, pinFl = 3'h0, bootSrc, pwrMode;
	wake_src_s req = 5'h00, pins;
	logic [5:0] enBus;
	int err_total = 0, checked = 0;
	logic [2:0] hiT [5] = '{3'h0, 3'h3, 3'h2, 3'h4, 3'h1};
	logic [2:0] flT [5] = '{3'h0, 3'h4, 3'h5, 3'h3, 3'h2};
	logic [2:0] bsT [5] = '{BOOT_INVALID, BOOT_USB, BOOT_I2C_USB,
		BOOT_I2C_ONLY, BOOT_SPI_USB};
	initial forever #12.5 mclk = ~mclk;
	wake_pin_model u_wake_pin_model (.mclk(mclk), .rstReq(rstReq),
		.coreOff(coreOff), .req(req), .nrst(nrst), .pins(pins));
	power_mode_boot_reset_ctrl u_power_mode_boot_reset_ctrl (
		.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .bootPinHigh(pinHi), .bootPinFloat(pinFl),
		.camRxRstPin(camRxRstPin), .dpPin(pins.dpLine),
		.dmPin(pins.dmLine), .ssResumePin(pins.ssResume),
		.vbusPin(pins.vbusDet), .ctsPin(pins.ctsLevel),
		.ioOutEnAllow(ioOutEnAllow), .camRxRst(camRxRst),
		.cpuPcRst(cpuPcRst), .coreRst(coreRst), .fwValid(fwValid),
		.bootSrc(bootSrc), .pwrMode(pwrMode), .cpuClkEn(cpuClkEn),
		.pllEn(pllEn), .usbPhyEn(usbPhyEn), .usbXcvrEn(usbXcvrEn),
		.cpuPwrEn(cpuPwrEn), .ioHold(ioHold));
	assign enBus = {cpuClkEn, pllEn, usbPhyEn, usbXcvrEn,
		cpuPwrEn, ioHold};
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	task automatic waitm(input logic [2:0] m);
		repeat (30) if (pwrMode !== m) cyc(1);
		chk(pwrMode, m);
	endtask
	task automatic mode(input logic [31:0] d, input logic [2:0] m);
		wr(ADDR_CTRL, d);
		cyc(1);
		chk(pwrMode, m);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 5; i++) begin
			rstReq <= 1'b1;
			pinHi <= hiT[i];
			pinFl <= flT[i];
			cyc(16);
			chk(ioOutEnAllow, 0);
			rstReq <= 1'b0;
			cyc(8);
			pinHi <= ~hiT[i];
			cyc(4);
			chk(bootSrc, bsT[i]);
			chk(ioOutEnAllow, 1);
		end
		$display("test boot done");
		rd(ADDR_STATUS, 32'h0B0);
		wr(ADDR_CTRL, 32'h10);
		wr(ADDR_WAKECFG, 32'h1);
		rd(8'hFC, 0);
		for (int i = 0; i < 5; i++) begin
			mode(32'h4, PM_SUSPEND);
			mode(32'h8, PM_SUSPEND);
			chk(enBus, PWR_SUSPEND);
			req <= wake_src_s'(5'h10 >> i);
			waitm(PM_NORMAL);
			chk(enBus, PWR_NORMAL);
			req <= 5'h00;
			cyc(6);
		end
		rd(ADDR_WAKECFG, 1);
		for (int i = 0; i < 2; i++) begin
			mode(32'h8, PM_STANDBY);
			req <= 5'h10;
			cyc(8);
			chk(pwrMode, PM_STANDBY);
			chk(enBus, PWR_STANDBY);
			req <= wake_src_s'(5'h02 >> i);
			waitm(PM_WAKE_STBY);
			waitm(PM_NORMAL);
			req <= 5'h00;
			cyc(6);
		end
		rd(ADDR_WAKECFG, 1);
		$display("test modes done");
		wr(ADDR_CTRL, 32'h1);
		cyc(1);
		chk(cpuPcRst, 1);
		chk(fwValid, 1);
		cyc(8);
		mode(32'h2, PM_DEVRST);
		chk(coreRst, 1);
		chk(ioOutEnAllow, 0);
		waitm(PM_NORMAL);
		chk(fwValid, 0);
		rd(ADDR_WAKECFG, 0);
		chk(camRxRst, 0);
		camRxRstPin <= 1'b1;
		cyc(4);
		chk(camRxRst, 1);
		chk(coreRst, 0);
		wr(ADDR_CTRL, 32'h10);
		coreOff <= 1'b1;
		cyc(4);
		coreOff <= 1'b0;
		cyc(8);
		chk(fwValid, 0);
		$display("test resets done");
		final_report;
	end
	// The tests need about 330 cycles; this leaves ample margin.
	initial begin
		repeat (4000) @(posedge mclk);
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report;
	end
endmodule
